// ==== rtl/link_cfg_pkg.sv ====
// Constants and carrier types for the per-link bus range and link type registers
package link_cfg_pkg;

  localparam int NUM_LINKS = 3;

  localparam logic [7:0] LINK0_BUS_RANGE_OFS = 8'h94;
  localparam logic [7:0] LINK0_TYPE_OFS      = 8'h98;
  localparam logic [7:0] LINK1_BUS_RANGE_OFS = 8'hb4;
  localparam logic [7:0] LINK1_TYPE_OFS      = 8'hb8;
  localparam logic [7:0] LINK2_BUS_RANGE_OFS = 8'hd4;
  localparam logic [7:0] LINK2_TYPE_OFS      = 8'hd8;

  localparam logic [7:0] BUS_RANGE_OFS [NUM_LINKS] =
    '{LINK0_BUS_RANGE_OFS, LINK1_BUS_RANGE_OFS, LINK2_BUS_RANGE_OFS};
  localparam logic [7:0] TYPE_OFS [NUM_LINKS] =
    '{LINK0_TYPE_OFS, LINK1_TYPE_OFS, LINK2_TYPE_OFS};

  // Bus range field layout
  localparam int UPSTREAM_LSB   = 0;
  localparam int DOWNSTREAM_LSB = 8;
  localparam int HIGHEST_LSB    = 16;
  localparam int BUS_FIELD_W    = 8;
  localparam logic [7:0] UPSTREAM_BUS_VALUE = 8'h00;

  // Link type field layout (matches link_status_t packing)
  localparam int CONNECTED_BIT   = 0;
  localparam int INIT_DONE_BIT   = 1;
  localparam int NONCOHERENT_BIT = 2;
  localparam int UNIPROC_BIT     = 3;
  localparam int PENDING_BIT     = 4;
  localparam int TYPE_USED_W     = 5;

  typedef struct packed {
    logic connect_pending_flag;
    logic uniproc_bridge_link_flag;
    logic noncoherent;
    logic init_done_flag;
    logic connected_flag;
  } link_status_t;

  typedef struct packed {
    logic [7:0] highest_bus_behind;
    logic [7:0] downstream_bus_index;
  } bus_range_t;

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  localparam bus_range_t   BUS_RANGE_RST = 16'h0000;
  // Determination is assumed in progress until the link logic says otherwise
  localparam link_status_t TYPE_RST      = 5'h10;

endpackage : link_cfg_pkg

// ==== rtl/link_bus_type_regs.sv ====
// Per-link bus range and link type registers in the node's configuration function
//
// Behaviour
// R1: The upstream bus field in bits 7..0 of each bus range register always reads zero.
// R2: The bus range of a link only takes effect while that link is noncoherent.
// R3: Bits 15..8 hold a writable downstream bus index set by configuration software.
// R4: Software sets the downstream bus index to zero on the link that carries the I/O hub.
// R5: Bits 23..16 hold a writable index of the highest bus behind the host bridge.
// R6: Hardware fills the link type bits after link initialization; software cannot write them.
// R7: Bit 0 shows the link connected and is valid only once the pending bit is clear.
// R8: Bit 1 shows initialization done and mirrors bit 5 of the link control register.
// R9: The noncoherent and uniprocessor bits are not valid before initialization is done.
// R10: Bit 2 reads 0 for a coherent link and 1 for a noncoherent link.
// R11: Bit 3 reads 1 for a uniprocessor coherent link to an external bridge, else 0.
// R12: Bit 4 reads 1 while connection is being determined and 0 once that is done.
// R13: Writes to read-only and reserved fields are ignored; each link has its own copies.
module link_bus_type_regs #(
  parameter int NUM_LINKS = link_cfg_pkg::NUM_LINKS
) (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       cfg_valid,
  input  wire link_cfg_pkg::cfg_req_t     cfg_req,
  output logic                            cfg_ack,
  output logic [31:0]                     cfg_rdata,
  input  wire link_cfg_pkg::link_status_t link_state       [NUM_LINKS],
  output link_cfg_pkg::bus_range_t        link_bus_range   [NUM_LINKS],
  output logic [NUM_LINKS-1:0]            link_range_valid
);

  link_cfg_pkg::link_status_t status_r  [NUM_LINKS];
  link_cfg_pkg::bus_range_t   range_r   [NUM_LINKS];
  logic [NUM_LINKS-1:0]       range_valid_r;
  logic                       ack_r;
  logic [31:0]                rdata_r;
  logic [31:0]                rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Per-link storage

  for (genvar gi = 0; gi < NUM_LINKS; gi++)
  begin : g_link
    // Only byte lanes 1 and 2 are writable; lanes 0 and 3 are dropped
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        range_r[gi] <= link_cfg_pkg::BUS_RANGE_RST;
      end
      else if (cfg_valid && cfg_req.wr && cfg_req.addr == link_cfg_pkg::BUS_RANGE_OFS[gi])
      begin
        if (cfg_req.be[1])
        begin
          range_r[gi].downstream_bus_index <= cfg_req.wdata[15:8]; // R3
        end
        if (cfg_req.be[2])
        begin
          range_r[gi].highest_bus_behind <= cfg_req.wdata[23:16]; // R5
        end
      end
    end

    // Status follows the link logic only; no configuration write reaches it
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        status_r[gi] <= link_cfg_pkg::TYPE_RST;
      end
      else
      begin
        status_r[gi].connect_pending_flag <= link_state[gi].connect_pending_flag; // R12 R6
        // Held low until determination ends so a stale value never shows
        status_r[gi].connected_flag <= link_state[gi].connected_flag
                                      & ~link_state[gi].connect_pending_flag; // R7
        status_r[gi].init_done_flag <= link_state[gi].init_done_flag; // R8
        status_r[gi].noncoherent <= link_state[gi].noncoherent
                                   & link_state[gi].init_done_flag; // R9 R10
        status_r[gi].uniproc_bridge_link_flag <= link_state[gi].uniproc_bridge_link_flag
                                                & link_state[gi].init_done_flag; // R9 R11
      end
    end

    // Routing sees the range only on an initialized noncoherent link
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        range_valid_r[gi] <= 1'b0;
      end
      else
      begin
        range_valid_r[gi] <= status_r[gi].init_done_flag & status_r[gi].noncoherent; // R2
      end
    end

    assign link_bus_range[gi] = range_r[gi];
  end

  assign link_range_valid = range_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    for (int i = 0; i < NUM_LINKS; i++)
    begin
      if (cfg_req.addr == link_cfg_pkg::BUS_RANGE_OFS[i])
      begin
        rdata_nxt = {8'h00, range_r[i], link_cfg_pkg::UPSTREAM_BUS_VALUE}; // R1 R13
      end
      if (cfg_req.addr == link_cfg_pkg::TYPE_OFS[i])
      begin
        rdata_nxt = {27'h000_0000, status_r[i]}; // R13
      end
    end
  end

  // Every access is answered one cycle later; unmapped reads return zero
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r   <= cfg_valid;
      rdata_r <= (cfg_valid && !cfg_req.wr) ? rdata_nxt : 32'h0000_0000;
    end
  end

  assign cfg_ack   = ack_r;
  assign cfg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_ack_next;
    cfg_valid |=> cfg_ack ##1 (!cfg_ack || $past(cfg_valid));
  endproperty
  a_ack_next: assert property (p_ack_next) // R13
    else $error("access not answered in the next cycle");

  property p_upstream_zero;
    cfg_valid && !cfg_req.wr && cfg_req.addr == link_cfg_pkg::LINK1_BUS_RANGE_OFS
      |=> cfg_rdata[7:0] == 8'h00 && cfg_rdata[31:24] == 8'h00;
  endproperty
  a_upstream_zero: assert property (p_upstream_zero) // R1
    else $error("upstream bus or reserved byte read non-zero");

  property p_downstream_write;
    cfg_valid && cfg_req.wr && cfg_req.be[1]
      && cfg_req.addr == link_cfg_pkg::LINK0_BUS_RANGE_OFS
      |=> link_bus_range[0].downstream_bus_index == $past(cfg_req.wdata[15:8]);
  endproperty
  a_downstream_write: assert property (p_downstream_write) // R3
    else $error("downstream bus index not written");

  property p_highest_readback;
    cfg_valid && cfg_req.wr && cfg_req.be[2]
      && cfg_req.addr == link_cfg_pkg::LINK2_BUS_RANGE_OFS
      ##1 cfg_valid && !cfg_req.wr && cfg_req.addr == link_cfg_pkg::LINK2_BUS_RANGE_OFS
      |=> cfg_rdata[23:16] == $past(cfg_req.wdata[23:16], 2);
  endproperty
  a_highest_readback: assert property (p_highest_readback) // R5
    else $error("highest bus behind did not read back");

  property p_lane_ignored;
    cfg_valid && cfg_req.wr && !cfg_req.be[1] && !cfg_req.be[2]
      |=> $stable(link_bus_range[0]) && $stable(link_bus_range[1])
          && $stable(link_bus_range[2]);
  endproperty
  a_lane_ignored: assert property (p_lane_ignored) // R13
    else $error("write without writable lanes changed a range");

  property p_type_read;
    cfg_valid && !cfg_req.wr && cfg_req.addr == link_cfg_pkg::LINK0_TYPE_OFS
      |=> cfg_rdata == {27'h000_0000, $past(status_r[0])};
  endproperty
  a_type_read: assert property (p_type_read) // R6
    else $error("link type read does not show status");

  property p_connected_gated;
    link_state[0].connect_pending_flag |=> !status_r[0].connected_flag
                                          && status_r[0].connect_pending_flag;
  endproperty
  a_connected_gated: assert property (p_connected_gated) // R7 R12
    else $error("connected shown while pending");

  property p_init_mirror;
    ##1 status_r[1].init_done_flag == $past(link_state[1].init_done_flag);
  endproperty
  a_init_mirror: assert property (p_init_mirror) // R8
    else $error("init done does not mirror control bit");

  property p_type_invalid;
    !link_state[1].init_done_flag
      |=> !status_r[1].noncoherent && !status_r[1].uniproc_bridge_link_flag;
  endproperty
  a_type_invalid: assert property (p_type_invalid) // R9
    else $error("type bits shown before init done");

  property p_type_value;
    link_state[2].init_done_flag
      |=> status_r[2].noncoherent == $past(link_state[2].noncoherent)
          && status_r[2].uniproc_bridge_link_flag
             == $past(link_state[2].uniproc_bridge_link_flag);
  endproperty
  a_type_value: assert property (p_type_value) // R10 R11
    else $error("type bits wrong after init done");

  property p_range_valid;
    link_state[0].init_done_flag && link_state[0].noncoherent
      ##1 link_state[0].init_done_flag && link_state[0].noncoherent
      |=> link_range_valid[0];
  endproperty
  a_range_valid: assert property (p_range_valid) // R2
    else $error("range not valid on noncoherent link");

  property p_range_coherent;
    !link_state[0].noncoherent |-> ##2 !link_range_valid[0];
  endproperty
  a_range_coherent: assert property (p_range_coherent) // R2
    else $error("range valid on coherent link");

  property p_upstream_zero_others;
    cfg_valid && !cfg_req.wr && (cfg_req.addr == link_cfg_pkg::LINK0_BUS_RANGE_OFS
      || cfg_req.addr == link_cfg_pkg::LINK2_BUS_RANGE_OFS)
      |=> cfg_rdata[7:0] == 8'h00;
  endproperty
  a_upstream_zero_others: assert property (p_upstream_zero_others) // R1
    else $error("upstream bus field read non-zero");

  property p_type_upper_zero;
    cfg_valid && !cfg_req.wr && (cfg_req.addr == link_cfg_pkg::LINK1_TYPE_OFS
      || cfg_req.addr == link_cfg_pkg::LINK2_TYPE_OFS)
      |=> cfg_rdata[31:5] == 27'h0;
  endproperty
  a_type_upper_zero: assert property (p_type_upper_zero) // R13
    else $error("reserved link type bits read non-zero");

  property p_write_no_data;
    cfg_valid && cfg_req.wr |=> cfg_ack && cfg_rdata == 32'h0000_0000;
  endproperty
  a_write_no_data: assert property (p_write_no_data) // R13
    else $error("write answer carried data");

  property p_idle_quiet;
    !cfg_valid |=> !cfg_ack && cfg_rdata == 32'h0000_0000;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) // R13
    else $error("answer without an access");

  property p_highest_write;
    cfg_valid && cfg_req.wr && cfg_req.be[2]
      && cfg_req.addr == link_cfg_pkg::LINK1_BUS_RANGE_OFS
      |=> link_bus_range[1].highest_bus_behind == $past(cfg_req.wdata[23:16]);
  endproperty
  a_highest_write: assert property (p_highest_write) // R5
    else $error("highest bus behind not written");

  property p_downstream_kept;
    cfg_valid && cfg_req.wr && !cfg_req.be[1]
      && cfg_req.addr == link_cfg_pkg::LINK1_BUS_RANGE_OFS
      |=> $stable(link_bus_range[1].downstream_bus_index);
  endproperty
  a_downstream_kept: assert property (p_downstream_kept) // R13
    else $error("downstream index changed without its lane");

  property p_links_separate;
    cfg_valid && cfg_req.wr && cfg_req.addr == link_cfg_pkg::LINK1_BUS_RANGE_OFS
      |=> $stable(link_bus_range[0]) && $stable(link_bus_range[2]);
  endproperty
  a_links_separate: assert property (p_links_separate) // R13
    else $error("write to one link changed another");

  property p_type2_read;
    cfg_valid && !cfg_req.wr && cfg_req.addr == link_cfg_pkg::LINK2_TYPE_OFS
      |=> cfg_rdata[4:0] == $past(status_r[2]);
  endproperty
  a_type2_read: assert property (p_type2_read) // R6
    else $error("link type read does not show status");

  property p_pending_set;
    link_state[2].connect_pending_flag |=> status_r[2].connect_pending_flag;
  endproperty
  a_pending_set: assert property (p_pending_set) // R12
    else $error("pending not shown");

  property p_pending_clear;
    !link_state[2].connect_pending_flag |=> !status_r[2].connect_pending_flag;
  endproperty
  a_pending_clear: assert property (p_pending_clear) // R12
    else $error("pending shown after determination");

  property p_connected_shown;
    link_state[1].connected_flag && !link_state[1].connect_pending_flag
      |=> status_r[1].connected_flag;
  endproperty
  a_connected_shown: assert property (p_connected_shown) // R7
    else $error("connected link not shown");

  property p_uniproc_shown;
    link_state[1].init_done_flag && link_state[1].uniproc_bridge_link_flag
      |=> status_r[1].uniproc_bridge_link_flag;
  endproperty
  a_uniproc_shown: assert property (p_uniproc_shown) // R11
    else $error("uniprocessor link not shown");

  property p_range_valid_link2;
    link_state[2].init_done_flag && link_state[2].noncoherent
      |-> ##2 link_range_valid[2];
  endproperty
  a_range_valid_link2: assert property (p_range_valid_link2) // R2
    else $error("range not valid on noncoherent link");

  property p_coherent_shown;
    link_state[0].init_done_flag && !link_state[0].noncoherent
      |=> !status_r[0].noncoherent;
  endproperty
  a_coherent_shown: assert property (p_coherent_shown) // R10
    else $error("coherent link shown as noncoherent");

endmodule : link_bus_type_regs

// ==== bench/link_bus_type_regs_tb.sv ====
// Self-checking bench for the per-link bus range and link type registers
module link_bus_type_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                       core_clk;
  logic                       sys_rst;
  logic                       cfg_valid;
  link_cfg_pkg::cfg_req_t     cfg_req;
  logic                       cfg_ack;
  logic [31:0]                cfg_rdata;
  link_cfg_pkg::link_status_t link_state [3];
  link_cfg_pkg::bus_range_t   link_bus_range [3];
  logic [2:0]                 link_range_valid;
  int                         bad_count;
  int                         tests_run;
  logic [31:0]                rd;

  // Two link status patterns; the second flips link0 coherent and releases link2
  localparam link_cfg_pkg::link_status_t PAT [2][3] = '{'{5'h07, 5'h0b, 5'h1c},
                                                      '{5'h03, 5'h0b, 5'h07}};
  localparam logic [4:0] TYPE_EXP [2][3] = '{'{5'h07, 5'h0b, 5'h10}, '{5'h03, 5'h0b, 5'h07}};
  localparam logic [2:0] VALID_EXP [2] = '{3'h1, 3'h4};

  link_bus_type_regs link_bus_type_regs_inst (
    .core_clk         (core_clk),
    .sys_rst          (sys_rst),
    .cfg_valid        (cfg_valid),
    .cfg_req          (cfg_req),
    .cfg_ack          (cfg_ack),
    .cfg_rdata        (cfg_rdata),
    .link_state       (link_state),
    .link_bus_range   (link_bus_range),
    .link_range_valid (link_range_valid)
  );

  always #12.5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_range(input link_cfg_pkg::bus_range_t got,
                           input link_cfg_pkg::bus_range_t exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t range port got %h exp %h", $time, got, exp);
    end
  endtask : chk_range

  // One access; the answer is checked at the falling edge right after the taking edge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata);
    @(posedge core_clk);
    cfg_valid <= 1'b1;
    cfg_req   <= '{wr: wr, addr: addr, be: be, wdata: wdata};
    @(posedge core_clk);
    cfg_valid <= 1'b0;
    @(negedge core_clk);
    if (cfg_ack !== 1'b1)
    begin
      bad_count++;
      $display("[FAIL] %0t no answer", $time);
      complete_run();
    end
    rd = cfg_rdata;
  endtask : access

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string what);
    access(1'b0, addr, 4'h0, 32'h0);
    chk_word(rd, exp, what);
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk  = 1'b0;
    sys_rst   = 1'b1;
    cfg_valid = 1'b0;
    cfg_req   = '0;
    bad_count = 0;
    tests_run = 0;
    rd        = '0;
    // Connected shown while still pending must read back as not connected
    link_state = '{5'h11, 5'h11, 5'h11};
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      rd_chk(link_cfg_pkg::BUS_RANGE_OFS[i], 32'h0, "range rst");
      rd_chk(link_cfg_pkg::TYPE_OFS[i], 32'h10, "type rst");
    end
    $display("test reset_values done");
    for (int i = 0; i < 3; i++)
      access(1'b1, link_cfg_pkg::BUS_RANGE_OFS[i], 4'hf,
             {8'hff, 8'(i + 16), 8'(i + 32), 8'hee});
    for (int i = 0; i < 3; i++)
    begin
      rd_chk(link_cfg_pkg::BUS_RANGE_OFS[i], {8'h0, 8'(i + 16), 8'(i + 32), 8'h0}, "range");
      chk_range(link_bus_range[i], {8'(i + 16), 8'(i + 32)});
    end
    chk_word({29'h0, link_range_valid}, 32'h0, "valid pend");
    access(1'b1, link_cfg_pkg::LINK1_BUS_RANGE_OFS, 4'h2, 32'h00004400);
    rd_chk(link_cfg_pkg::LINK1_BUS_RANGE_OFS, 32'h00114400, "be1");
    access(1'b1, link_cfg_pkg::LINK1_BUS_RANGE_OFS, 4'h4, 32'h00550000);
    rd_chk(link_cfg_pkg::LINK1_BUS_RANGE_OFS, 32'h00554400, "be2");
    access(1'b1, link_cfg_pkg::LINK1_BUS_RANGE_OFS, 4'h9, 32'hffffffff);
    rd_chk(link_cfg_pkg::LINK1_BUS_RANGE_OFS, 32'h00554400, "be03");
    access(1'b1, link_cfg_pkg::LINK2_BUS_RANGE_OFS, 4'h2, 32'h0);
    rd_chk(link_cfg_pkg::LINK2_BUS_RANGE_OFS, 32'h00120000, "hub link");
    rd_chk(link_cfg_pkg::LINK0_BUS_RANGE_OFS, 32'h00102000, "link0 kept");
    access(1'b1, link_cfg_pkg::LINK0_TYPE_OFS, 4'hf, 32'hffffffff);
    rd_chk(link_cfg_pkg::LINK0_TYPE_OFS, 32'h10, "type wr");
    access(1'b1, 8'h9c, 4'hf, 32'hffffffff);
    rd_chk(8'h9c, 32'h0, "unmapped");
    // Write then read with no idle cycle between them
    @(posedge core_clk);
    cfg_valid <= 1'b1;
    cfg_req   <= '{wr: 1'b1, addr: link_cfg_pkg::LINK2_BUS_RANGE_OFS, be: 4'h4,
                   wdata: 32'h0077_0000};
    @(posedge core_clk);
    cfg_req   <= '{wr: 1'b0, addr: link_cfg_pkg::LINK2_BUS_RANGE_OFS, be: 4'h0, wdata: 32'h0};
    @(posedge core_clk);
    cfg_valid <= 1'b0;
    @(negedge core_clk);
    chk_word({31'h0, cfg_ack}, 32'h1, "b2b ack");
    chk_word(cfg_rdata, 32'h0077_0000, "b2b read");
    $display("test register_access done");
    for (int p = 0; p < 2; p++)
    begin
      @(posedge core_clk);
      link_state <= PAT[p];
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk_word({29'h0, link_range_valid}, {29'h0, VALID_EXP[p]}, "valid");
      for (int i = 0; i < 3; i++)
        rd_chk(link_cfg_pkg::TYPE_OFS[i], {27'h0, TYPE_EXP[p][i]}, "type");
    end
    $display("test link_status done");
    // Reset again after traffic: written ranges must fall back to zero
    @(posedge core_clk);
    link_state <= '{5'h11, 5'h11, 5'h11};
    sys_rst    <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      rd_chk(link_cfg_pkg::BUS_RANGE_OFS[i], 32'h0, "range rerst");
      chk_range(link_bus_range[i], 16'h0000);
      rd_chk(link_cfg_pkg::TYPE_OFS[i], 32'h10, "type rerst");
    end
    chk_word({29'h0, link_range_valid}, 32'h0, "valid rerst");
    $display("test mid_reset done");
    complete_run();
  end

endmodule : link_bus_type_regs_tb
